// ### rtl/acc_top.sv
`timescale 1ns/1ps
// Function
// (RL1) Output bit is high when positive input exceeds negative input.
// (RL2) Raw result passes a synchroniser, one to two cycles latency.
// (RL3) Flag bit 4 sets on the edge chosen by the mode field.
// (RL4) Interrupt requested when flag, enable and global enable are all set.
// (RL5) Flag clears on vector taken or software writing one to it.
// (RL6) Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// (RL7) Bit 7 set switches comparator power off.
// (RL8) Software clears interrupt enable before changing disable bit.
// (RL9) Software clears interrupt enable before changing mode field.
// (RL10) Bit 6 selects bandgap as positive input, else positive pin.
// (RL11) Bit 2 routes comparator output to timer capture front end.
// (RL12) Software sets capture interrupt enable in timer mask for capture irq.
// (RL13) Negative pin used when mux enable clear or converter enabled.
// (RL14) Else channel select low bits pick converter pin 0 to 7.
// (RL15) Edges from current vs previous synchronised output; controls reset zero.
module acc_top
  import acc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  input  wire logic        cmp_raw_i,
  input  wire logic        global_irq_enable_i,
  input  wire logic        vector_taken_i,
  input  wire logic        converter_enable_i,
  input  wire logic [2:0]  channel_select_low_i,
  output acc_analog_type   analog_o,
  output logic             capture_src_o,
  output logic             comparator_irq_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////
  acc_ctrl_type ctrl_reg;
  logic         mux_enable_reg;
  logic         flag_reg;
  logic         out_prev_reg;
  logic [2:0]   evt_status_reg;
  logic [2:0]   evt_enable_reg;
  logic         ack_reg;
  logic [31:0]  dat_reg;
  logic         cmp_sync;
  logic         edge_hit;
  logic         rise;
  logic         fall;
  logic         wr_stb;
  logic         rd_stb;
  logic [2:0]   evt_now;
  logic [3:0]   addr;

  function automatic logic [7:0] ctrl_byte(input acc_ctrl_type c, input logic o,
                                           input logic f);
    ctrl_byte = {c.disable_cmp, c.bandgap_sel, o, f, c.irq_enable, c.capture_en,
                 c.irq_mode};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Analog core compares already-selected inputs; result arrives raw
  acc_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (cmp_raw_i),
    .sync_o  (cmp_sync)
  ); // [RL1] [RL2]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_prev_reg <= 1'b0;
    end else begin
      out_prev_reg <= cmp_sync; // [RL15]
    end
  end

  assign rise = cmp_sync & ~out_prev_reg; // [RL15]
  assign fall = ~cmp_sync & out_prev_reg; // [RL15]

  // Reserved mode fires no flag edge; rise and fall still reach the event bits
  always_comb begin
    unique case (acc_mode_type'(ctrl_reg.irq_mode))
      ACC_MODE_TOGGLE:   edge_hit = rise | fall; // [RL6]
      ACC_MODE_RESERVED: edge_hit = 1'b0; // [RL6]
      ACC_MODE_FALL:     edge_hit = fall; // [RL6]
      ACC_MODE_RISE:     edge_hit = rise; // [RL6]
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  assign addr   = adr_i[3:0];
  assign wr_stb = cyc_i & stb_i & we_i & ~ack_reg & sel_i[0];
  assign rd_stb = cyc_i & stb_i & ~we_i & ~ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= cyc_i & stb_i & ~ack_reg;
    end
  end

  assign ack_o = ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= acc_ctrl_type'(ACC_CTRL_RESET[5:0]); // [RL15]
    end else if (wr_stb && addr == ACC_CTRL_STATUS_ADDR && adr_i[4] == 1'b0) begin
      ctrl_reg.disable_cmp <= dat_i[ACC_DISABLE_BIT]; // [RL7]
      ctrl_reg.bandgap_sel <= dat_i[ACC_BANDGAP_BIT]; // [RL10]
      ctrl_reg.irq_enable  <= dat_i[ACC_IRQ_ENABLE_BIT]; // [RL4]
      ctrl_reg.capture_en  <= dat_i[ACC_CAPTURE_BIT]; // [RL11]
      ctrl_reg.irq_mode    <= dat_i[1:0]; // [RL6]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mux_enable_reg <= ACC_SFN_RESET[ACC_MUX_ENABLE_BIT]; // [RL15]
    end else if (wr_stb && addr == ACC_SPECIAL_FN_ADDR && adr_i[4] == 1'b0) begin
      mux_enable_reg <= dat_i[ACC_MUX_ENABLE_BIT]; // [RL13]
    end
  end

  // Set wins over any clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
    end else if (edge_hit) begin
      flag_reg <= 1'b1; // [RL3]
    end else if (vector_taken_i ||
                 (wr_stb && addr == ACC_CTRL_STATUS_ADDR && adr_i[4] == 1'b0 &&
                  dat_i[ACC_IRQ_FLAG_BIT])) begin
      flag_reg <= 1'b0; // [RL5]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event bits: 0 flag set, 1 rise, 2 fall
  assign evt_now = {fall, rise, edge_hit};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_status_reg <= 3'h0;
    end else if (wr_stb && addr == ACC_EVT_CLEAR_ADDR && adr_i[4] == 1'b0) begin
      evt_status_reg <= (evt_status_reg & ~dat_i[2:0]) | evt_now;
    end else begin
      evt_status_reg <= evt_status_reg | evt_now;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_enable_reg <= 3'h0;
    end else if (wr_stb && addr == ACC_EVT_ENABLE_ADDR && adr_i[4] == 1'b1) begin
      evt_enable_reg <= dat_i[2:0];
    end
  end

  assign irq_o = |(evt_status_reg & evt_enable_reg);

  ////////////////////////////////////////////////////////////////////////
  // Unmapped offsets read zero and ignore writes; only adr_i[4:0] is decoded, so higher addresses alias
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0;
    end else if (rd_stb) begin
      dat_reg <= 32'h0;
      if (adr_i[4] == 1'b0) begin
        unique case (addr)
          ACC_CTRL_STATUS_ADDR: dat_reg[7:0] <= ctrl_byte(ctrl_reg, cmp_sync, flag_reg);
          ACC_SPECIAL_FN_ADDR:  dat_reg[ACC_MUX_ENABLE_BIT] <= mux_enable_reg;
          ACC_EVT_STATUS_ADDR:  dat_reg[2:0] <= evt_status_reg;
          default:              dat_reg <= 32'h0;
        endcase
      end else if (addr == ACC_EVT_ENABLE_ADDR) begin
        dat_reg[2:0] <= evt_enable_reg;
      end
    end
  end

  assign dat_o = dat_reg;

  ////////////////////////////////////////////////////////////////////////
  assign comparator_irq_o = flag_reg & ctrl_reg.irq_enable & global_irq_enable_i; // [RL4]
  assign capture_src_o    = ctrl_reg.capture_en & cmp_sync; // [RL11]

  always_comb begin
    analog_o.power_down  = ctrl_reg.disable_cmp; // [RL7]
    analog_o.pos_bandgap = ctrl_reg.bandgap_sel; // [RL10]
    analog_o.neg_use_mux = mux_enable_reg & ~converter_enable_i; // [RL13]
    analog_o.neg_channel = analog_o.neg_use_mux ? channel_select_low_i : 3'h0; // [RL14]
  end

endmodule

// ### rtl/acc_pkg.sv
package acc_pkg;

  // Register byte addresses on the Wishbone slave
  localparam logic [3:0] ACC_CTRL_STATUS_ADDR = 4'h0;
  localparam logic [3:0] ACC_SPECIAL_FN_ADDR  = 4'h4;
  localparam logic [3:0] ACC_EVT_STATUS_ADDR  = 4'h8;
  localparam logic [3:0] ACC_EVT_CLEAR_ADDR   = 4'hc;
  localparam logic [3:0] ACC_EVT_ENABLE_ADDR  = 4'h0;

  // Control/status and special function bit positions
  localparam int ACC_DISABLE_BIT    = 7;
  localparam int ACC_BANDGAP_BIT    = 6;
  localparam int ACC_OUTPUT_BIT     = 5;
  localparam int ACC_IRQ_FLAG_BIT   = 4;
  localparam int ACC_IRQ_ENABLE_BIT = 3;
  localparam int ACC_CAPTURE_BIT    = 2;
  localparam int ACC_MUX_ENABLE_BIT = 3;

  localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
  localparam logic [7:0] ACC_SFN_RESET  = 8'h00;
  localparam int         ACC_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE   = 2'h0,
    ACC_MODE_RESERVED = 2'h1,
    ACC_MODE_FALL     = 2'h2,
    ACC_MODE_RISE     = 2'h3
  } acc_mode_type;

  typedef struct packed {
    logic       disable_cmp;
    logic       bandgap_sel;
    logic       irq_enable;
    logic       capture_en;
    logic [1:0] irq_mode;
  } acc_ctrl_type;

  typedef struct packed {
    logic       power_down;
    logic       pos_bandgap;
    logic       neg_use_mux;
    logic [2:0] neg_channel;
  } acc_analog_type;

endpackage

// ### rtl/acc_sync.sv
`timescale 1ns/1ps
module acc_sync
  import acc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic [ACC_SYNC_STAGES-1:0] stage_reg;

  // Only the last stage is read outside
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[ACC_SYNC_STAGES-2:0], async_i};
    end
  end

  assign sync_o = stage_reg[ACC_SYNC_STAGES-1];

endmodule

// ### dv/acc_analog_model.sv
`timescale 1ns/1ps
module acc_analog_model
  import acc_pkg::*;
(
  input  wire acc_analog_type cfg_i,
  input  wire logic [7:0]     pos_pin_i,
  input  wire logic [7:0]     neg_pin_i,
  input  wire logic [63:0]    conv_pins_i,
  output logic                cmp_o
);
  // Level is arbitrary, only needs to sit inside the test range
  localparam logic [7:0] BANDGAP_LEVEL = 8'h80;
  logic [7:0] pos;
  logic [7:0] neg;
  always_comb begin
    pos = cfg_i.pos_bandgap ? BANDGAP_LEVEL : pos_pin_i;
    neg = cfg_i.neg_use_mux ? conv_pins_i[cfg_i.neg_channel*8 +: 8] : neg_pin_i;
    // Unpowered core reads low
    cmp_o = !cfg_i.power_down && (pos > neg);
  end
endmodule

// ### dv/acc_properties.sv
`timescale 1ns/1ps
module acc_properties
  import acc_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic           cyc_i,
  input  wire logic           stb_i,
  input  wire logic           ack_o,
  input  wire logic           cmp_raw_i,
  input  wire logic           global_irq_enable_i,
  input  wire logic           converter_enable_i,
  input  wire logic [2:0]     channel_select_low_i,
  input  wire acc_analog_type analog_o,
  input  wire logic           capture_src_o,
  input  wire logic           comparator_irq_o,
  input  wire logic           irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack unasked");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  // Latency may be two or three edges here
  a_sync_delay: assert property (capture_src_o |-> $past(cmp_raw_i, 2) || $past(cmp_raw_i, 3))
    else $error("sync latency");
  a_irq_global: assert property (comparator_irq_o |-> global_irq_enable_i)
    else $error("irq without global");
  a_mux_conv: assert property (analog_o.neg_use_mux |-> !converter_enable_i)
    else $error("mux with converter on");
  a_chan_pass: assert property (analog_o.neg_use_mux |-> analog_o.neg_channel == channel_select_low_i)
    else $error("channel");
  a_chan_idle: assert property (!analog_o.neg_use_mux |-> analog_o.neg_channel == 3'h0)
    else $error("channel idle");
  c_ack: cover property (ack_o);
  c_irq: cover property (comparator_irq_o);
  c_mux: cover property (analog_o.neg_use_mux);
  c_evt: cover property (irq_o);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind acc_top acc_properties i_acc_properties (.*);

// ### dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module tb_top
  import acc_pkg::*;
;
  logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, glb = 0, vec = 0, cen = 0;
  logic ack, cap, cirq, irq, raw;
  logic [31:0] adr = 0, dat = 0, rdat, q;
  logic [2:0] ch = 0;
  logic [7:0] vp = 8'h10, vn = 8'h80;
  logic [63:0] conv = 64'hffff_00ff_ffff_ffff;
  acc_analog_type ana;
  int failures = 0, tests_run = 0;
  acc_top i_acc_top (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .dat_o(rdat),
    .sel_i(4'hf), .we_i(we), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .cmp_raw_i(raw),
    .global_irq_enable_i(glb), .vector_taken_i(vec), .converter_enable_i(cen),
    .channel_select_low_i(ch), .analog_o(ana), .capture_src_o(cap),
    .comparator_irq_o(cirq), .irq_o(irq));
  acc_analog_model i_acc_analog_model (.cfg_i(ana), .pos_pin_i(vp), .neg_pin_i(vn),
    .conv_pins_i(conv), .cmp_o(raw));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic finish_test;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      failures++;
      finish_test();
    end
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    wb(0, a, 8'h00);
    `CHK(q, {24'h0, e})
  endtask
  task automatic settle;
    repeat (4) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_modes;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wb(1, 0, {6'h0, m});
      vp <= 8'h10;
      settle();
      wb(1, 0, {6'h4, m});
      vp <= 8'hf0;
      settle();
      rd(0, {3'h1, m == 0 || m == 3, 2'h0, m});
      wb(1, 0, {6'h4, m});
      vp <= 8'h10;
      settle();
      rd(0, {3'h0, m == 0 || m == 2, 2'h0, m});
    end
  endtask
  task automatic t_irq;
    wb(1, 0, 8'h1b);
    vp <= 8'hf0;
    settle();
    `CHK(cirq, 1'b0)
    glb <= 1;
    @(posedge clk_i);
    @(posedge clk_i);
    `CHK(cirq, 1'b1)
    vec <= 1;
    @(posedge clk_i);
    vec <= 0;
    @(posedge clk_i);
    `CHK(cirq, 1'b0)
    wb(1, 32'h10, 8'h02);
    `CHK(irq, 1'b1)
    rd(8, 8'h07);
    wb(1, 32'hc, 8'h07);
    rd(8, 8'h00);
    vp <= 8'h10;
    settle();
    `CHK(irq, 1'b0)
    wb(1, 0, 8'h00);
  endtask
  task automatic t_route;
    wb(1, 0, 8'h04);
    vp <= 8'hf0;
    settle();
    `CHK(cap, 1'b1)
    vp <= 8'h10;
    @(posedge clk_i);
    @(posedge clk_i);
    `CHK(cap, 1'b1)
    settle();
    `CHK(cap, 1'b0)
    wb(1, 0, 8'h00);
    vp <= 8'hf0;
    settle();
    `CHK(cap, 1'b0)
  endtask
  task automatic t_analog;
    vn <= 8'h40;
    vp <= 8'h10;
    // Reserved mode keeps the flag quiet while inputs move
    wb(1, 0, 8'h51);
    settle();
    rd(0, 8'h61);
    wb(1, 4, 8'h08);
    for (int k = 0; k < 8; k++) begin
      ch <= k[2:0];
      wb(1, 0, 8'h01);
      settle();
      rd(0, k == 5 ? 8'h21 : 8'h01);
    end
    ch <= 3'h5;
    cen <= 1;
    settle();
    rd(0, 8'h01);
    wb(1, 0, 8'h81);
    `CHK(ana.power_down, 1'b1)
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    rd(0, 8'h00);
    `CHK(ana, 6'h00)
    rd(32'h14, 8'h00);
    t_modes();
    t_irq();
    t_route();
    t_analog();
    finish_test();
  end
endmodule
